// ### tmap_regs.svh
`ifndef TMAP_REGS_SVH
`define TMAP_REGS_SVH
// ----------------------------------------------------------------------
// aggregate frame layout (bytes per 125 us frame)
// ----------------------------------------------------------------------
`define TMAP_FRAME_BYTES 10'd537
`define TMAP_TU_COUNT 4'd14
`define TMAP_TU_LAST 4'd13
`define TMAP_TU_COLS 6'd36
`define TMAP_TU_FIRST_POS 10'd1
`define TMAP_TU_END_POS 10'd504
// ----------------------------------------------------------------------
// overhead field values
// ----------------------------------------------------------------------
`define TMAP_SIG_LABEL 3'h3
`define TMAP_SS_TU12 2'h2
`define TMAP_NDF_NORMAL 4'h6
`define TMAP_SPARE_FILL 8'h00
`define TMAP_STUFF_FILL 8'h00
`define TMAP_AIS_FILL 8'hff
// ----------------------------------------------------------------------
// elastic store
// ----------------------------------------------------------------------
`define TMAP_STORE_AW 3
`define TMAP_FILL_HIGH 4'd6
`define TMAP_FILL_LOW 4'd2
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TMAP_CORE_CLK_PS 8000
`define TMAP_AIS_TIME_US 1000
`endif

// ### tmap_pkg.sv
package tmap_pkg;
  // one stored byte with its frame start mark
  typedef struct packed {
    logic [7:0] data;
    logic fs;
  } tmap_entry_t;
  // aggregate byte towards path termination
  typedef struct packed {
    logic valid;
    logic driven;
    logic fs;
    logic mfs;
    logic [7:0] data;
  } tmap_agg_t;
  // pending justification for the current multiframe
  typedef enum logic [1:0] {JUST_NONE, JUST_POS, JUST_NEG} tmap_just_t;
endpackage

// ### tmap_mapper.sv
`timescale 1ns/1ns
`include "tmap_regs.svh"
// Operation
// [RULE1] each tributary bound to one slot 0..13
// [RULE2] one driver per slot, others refused
// [RULE3] management must fill every slot
// [RULE4] signal label 011 in status bits 3-5
// [RULE5] multiframe indicator aligned to multiframe start
// [RULE6] fixed stuff bytes carry any value
// [RULE7] drive access point only when activated
// [RULE8] tributary is 2240 kbit/s stream with phase
// [RULE9] store written on tributary clock
// [RULE10] store read on path clock, justification gated
// [RULE11] frame phase carried in pointer value
// [RULE12] positive justification skips read after V3
// [RULE13] negative justification reads extra into V3
// [RULE14] pointer in first two bytes per multiframe
// [RULE15] pointer size bits set to 10
// [RULE16] spare pointer-area byte carries any value
// [RULE17] server fail forces all ones within 1 ms
// [RULE18] unconnected server fail treated as low
// [RULE19] termination stage passes signals unchanged
// [RULE20] justify on fill level, pointer follows
module tmap_mapper #(
  parameter int AIS_LIMIT_CYC = (`TMAP_AIS_TIME_US * 1000000) / `TMAP_CORE_CLK_PS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [13:0] tribClk,
  input wire tmap_pkg::tmap_entry_t [13:0] tribIn,
  input wire logic [13:0] tribWrEn,
  input wire logic [13:0] serverFailInput,
  input wire logic [13:0] activationControl,
  input wire logic [13:0][3:0] slotSel,
  input wire logic aggActivationControl,
  input wire logic pathTimingByteEn,
  input wire logic pathTimingFrameStart,
  input wire logic pathTimingMultiframeStart,
  output tmap_pkg::tmap_agg_t aggOut,
  output logic [13:0] slotDenied
);
  // ----------------------------------------------------------------------
  // aggregate frame position (path clock domain)
  // ----------------------------------------------------------------------
  logic [9:0] pos_r, pos_nxt; // byte index in frame
  logic [1:0] mfPhase_r, mfPhase_nxt; // frame index in multiframe
  logic [9:0] curPos; // position of the byte slot being served now
  logic [1:0] curPhase;
  logic [9:0] posM1;
  logic inTu; // slot belongs to a tributary unit
  logic [3:0] curTu;
  logic [5:0] curCol;
  // a frame start forces position zero so the counter never drifts
  always_comb begin
    curPos = pathTimingFrameStart ? 10'd0 : pos_r;
    curPhase = (pathTimingFrameStart && pathTimingMultiframeStart) ? 2'd0 : mfPhase_r;
    posM1 = curPos - `TMAP_TU_FIRST_POS;
    inTu = (curPos >= `TMAP_TU_FIRST_POS) && (curPos <= `TMAP_TU_END_POS);
    curTu = 4'(posM1 % 10'(`TMAP_TU_COUNT));
    curCol = 6'(posM1 / 10'(`TMAP_TU_COUNT));
    pos_nxt = pos_r;
    mfPhase_nxt = mfPhase_r;
    if (pathTimingByteEn) begin
      pos_nxt = (curPos == `TMAP_FRAME_BYTES - 10'd1) ? 10'd0 : curPos + 10'd1;
      mfPhase_nxt = (curPos == `TMAP_FRAME_BYTES - 10'd1) ? curPhase + 2'd1 : curPhase;
    end
  end
  // position registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 10'd0;
      mfPhase_r <= 2'd0;
    end else begin
      pos_r <= pos_nxt;
      mfPhase_r <= mfPhase_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // slot ownership
  // ----------------------------------------------------------------------
  logic [13:0] granted; // tributary owns its slot
  logic [13:0] deniedNow;
  // lowest active index wins a contested slot; the rest stay off the bus
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      deniedNow[i] = activationControl[i] && (slotSel[i] > `TMAP_TU_LAST); // RULE1
      for (int j = 0; j < i; j++) begin
        if (activationControl[i] && activationControl[j] && slotSel[i] == slotSel[j]) begin
          deniedNow[i] = 1'b1; // RULE2
        end
      end
      granted[i] = activationControl[i] && !deniedNow[i]; // RULE7
    end
  end
  assign slotDenied = deniedNow;
  // ----------------------------------------------------------------------
  // per tributary elastic store, pointer and alarm
  // ----------------------------------------------------------------------
  logic [13:0] hit; // tributary owns the slot served now
  logic [13:0] rdReq; // pop one byte this slot
  logic [13:0][7:0] tuByte; // byte offered by each tributary
  tmap_pkg::tmap_just_t [13:0] justState;
  function automatic logic [3:0] gray2bin(input logic [3:0] g);
    gray2bin = {g[3], g[3] ^ g[2], g[3] ^ g[2] ^ g[1], g[3] ^ g[2] ^ g[1] ^ g[0]};
  endfunction
  for (genvar t = 0; t < 14; t++) begin : gTrib
    // store memory, written only in the tributary domain
    tmap_pkg::tmap_entry_t mem [0:7];
    logic [3:0] wrBin_r, wrBin_nxt; // write pointer, tributary clock
    logic [3:0] wrGray_r;
    logic [3:0] rdGraySa_r, rdGraySb_r; // read pointer into tributary clock
    logic full;
    // path clock side
    logic [3:0] wrGraySa_r, wrGraySb_r; // write pointer into path clock
    logic [3:0] rdBin_r, rdBin_nxt;
    logic [3:0] rdGray_r;
    logic [3:0] fill;
    logic sfSa_r, sfSb_r; // server fail synchroniser
    logic [9:0] ptr_r, ptr_nxt; // pointer value of the frame start
    logic [9:0] posCnt_r, posCnt_nxt; // payload offset from the V2 byte
    tmap_pkg::tmap_just_t just_r, just_nxt;
    logic [9:0] ptrWord;
    tmap_pkg::tmap_entry_t head;
    // writes stop when full; a full store means the source runs fast
    always_comb begin
      full = (wrBin_r - gray2bin(rdGraySb_r)) == 4'd8;
      wrBin_nxt = (tribWrEn[t] && !full) ? wrBin_r + 4'd1 : wrBin_r; // RULE9
    end
    // tributary clock registers
    always_ff @(posedge tribClk[t] or negedge rst_n) begin
      if (!rst_n) begin
        wrBin_r <= 4'd0;
        wrGray_r <= 4'd0;
        rdGraySa_r <= 4'd0;
        rdGraySb_r <= 4'd0;
      end else begin
        wrBin_r <= wrBin_nxt;
        wrGray_r <= wrBin_nxt ^ (wrBin_nxt >> 1);
        rdGraySa_r <= rdGray_r;
        rdGraySb_r <= rdGraySa_r;
      end
    end
    // memory write, no reset needed on data
    always_ff @(posedge tribClk[t]) begin
      if (tribWrEn[t] && !full) begin
        mem[wrBin_r[2:0]] <= tribIn[t]; // RULE9
      end
    end
    // justification, pointer and read gating
    always_comb begin
      fill = gray2bin(wrGraySb_r) - rdBin_r;
      head = mem[rdBin_r[2:0]];
      hit[t] = granted[t] && inTu && (curTu == slotSel[t]) && pathTimingByteEn;
      just_nxt = just_r;
      ptr_nxt = ptr_r;
      posCnt_nxt = posCnt_r;
      rdReq[t] = 1'b0;
      if (hit[t]) begin
        if (curCol == 6'd0) begin
          if (curPhase == 2'd0) begin
            // decide once per multiframe from the fill level
            if (fill >= `TMAP_FILL_HIGH) begin
              just_nxt = tmap_pkg::JUST_NEG; // RULE20
            end else if (fill <= `TMAP_FILL_LOW) begin
              just_nxt = tmap_pkg::JUST_POS; // RULE20
            end else begin
              just_nxt = tmap_pkg::JUST_NONE;
            end
          end else if (curPhase == 2'd1) begin
            posCnt_nxt = 10'd0;
          end else if (curPhase == 2'd2 && just_r == tmap_pkg::JUST_NEG) begin
            rdReq[t] = fill != 4'd0; // RULE13
          end
        end else if (!(curPhase == 2'd2 && curCol == 6'd1 && just_r == tmap_pkg::JUST_POS)) begin
          rdReq[t] = fill != 4'd0; // RULE10 RULE12
        end
        if (curCol != 6'd0) begin
          posCnt_nxt = posCnt_r + 10'd1;
        end
        if (rdReq[t] && head.fs) begin
          ptr_nxt = posCnt_r; // RULE11 RULE20
        end
      end
      rdBin_nxt = rdReq[t] ? rdBin_r + 4'd1 : rdBin_r; // RULE10
      // interleaved I/D inversion announces the adjustment
      ptrWord = ptr_r;
      if (just_r == tmap_pkg::JUST_POS) begin
        ptrWord = ptr_r ^ 10'h2aa;
      end else if (just_r == tmap_pkg::JUST_NEG) begin
        ptrWord = ptr_r ^ 10'h155;
      end
      tuByte[t] = head.data;
      if (curCol == 6'd0) begin
        unique case (curPhase)
          2'd0: tuByte[t] = {`TMAP_NDF_NORMAL, `TMAP_SS_TU12, ptrWord[9:8]}; // RULE14 RULE15
          2'd1: tuByte[t] = ptrWord[7:0]; // RULE14
          2'd2: tuByte[t] = rdReq[t] ? head.data : `TMAP_SPARE_FILL; // RULE13
          2'd3: tuByte[t] = `TMAP_SPARE_FILL; // RULE16
        endcase
      end else if (!rdReq[t]) begin
        tuByte[t] = `TMAP_SPARE_FILL; // RULE12
      end
      if (sfSb_r) begin
        tuByte[t] = `TMAP_AIS_FILL; // RULE17
      end
    end
    assign justState[t] = just_r;
    // path clock registers
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        wrGraySa_r <= 4'd0;
        wrGraySb_r <= 4'd0;
        rdBin_r <= 4'd0;
        rdGray_r <= 4'd0;
        sfSa_r <= 1'b0;
        sfSb_r <= 1'b0;
        ptr_r <= 10'd0;
        posCnt_r <= 10'd0;
        just_r <= tmap_pkg::JUST_NONE;
      end else begin
        wrGraySa_r <= wrGray_r;
        wrGraySb_r <= wrGraySa_r;
        rdBin_r <= rdBin_nxt;
        rdGray_r <= rdBin_nxt ^ (rdBin_nxt >> 1);
        sfSa_r <= serverFailInput[t]; // RULE18
        sfSb_r <= sfSa_r;
        ptr_r <= ptr_nxt;
        posCnt_r <= posCnt_nxt;
        just_r <= just_nxt;
      end
    end
  end
  // ----------------------------------------------------------------------
  // aggregate output byte
  // ----------------------------------------------------------------------
  tmap_pkg::tmap_agg_t agg_r, agg_nxt;
  logic [7:0] tuSel; // group stage output, passed through unchanged
  logic tuDriven;
  // the group termination stage adds nothing: owner byte goes straight out
  always_comb begin
    tuSel = 8'h00;
    tuDriven = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if (hit[i]) begin
        tuSel = tuByte[i]; // RULE19
        tuDriven = 1'b1;
      end
    end
    agg_nxt = agg_r;
    agg_nxt.valid = 1'b0;
    if (pathTimingByteEn) begin
      agg_nxt.valid = aggActivationControl; // RULE7
      agg_nxt.fs = pathTimingFrameStart; // RULE19
      agg_nxt.mfs = pathTimingFrameStart && pathTimingMultiframeStart; // RULE19
      agg_nxt.driven = aggActivationControl && (!inTu || tuDriven);
      if (curPos == 10'd0) begin
        // bit 1 is the msb; only label and multiframe bits are ours
        agg_nxt.data = {2'b00, `TMAP_SIG_LABEL, curPhase + 2'd1, 1'b0}; // RULE4 RULE5
      end else if (inTu) begin
        agg_nxt.data = tuSel;
      end else begin
        agg_nxt.data = `TMAP_STUFF_FILL; // RULE6
      end
      if (!agg_nxt.driven) begin
        agg_nxt.data = 8'h00; // RULE7
      end
    end
  end
  // output register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      agg_r <= '0;
    end else begin
      agg_r <= agg_nxt;
    end
  end
  assign aggOut = agg_r;
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [17:0] aisWait_r; // cycles that tributary 3 alarm waits for ones
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aisWait_r <= 18'd0;
    end else if (serverFailInput[3] && tuByte[3] != `TMAP_AIS_FILL) begin
      aisWait_r <= aisWait_r + 18'd1;
    end else begin
      aisWait_r <= 18'd0;
    end
  end

  sequence statusSlot_s;
    pathTimingByteEn && (curPos == 10'd0) && aggActivationControl;
  endsequence
  sequence mfStart_s;
    pathTimingByteEn && pathTimingFrameStart && pathTimingMultiframeStart;
  endsequence
  sequence v1Slot0_s;
    hit[0] && (curCol == 6'd0) && (curPhase == 2'd0);
  endsequence
  sequence sfHeld_s;
    serverFailInput[3] [*4];
  endsequence

  sigLabel_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
    statusSlot_s |=> aggOut.data[5:3] == `TMAP_SIG_LABEL)
    else $error("signal label wrong");
  mfiAlign_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    mfStart_s ##0 aggActivationControl |=> aggOut.data[2:1] == 2'd1)
    else $error("multiframe indicator out of phase");
  sizeBits_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE15
    v1Slot0_s ##0 !gTrib[0].sfSb_r ##0 aggActivationControl |=> aggOut.data[3:2] == 2'd2)
    else $error("pointer size bits wrong");
  badSlot_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
    (activationControl[5] && slotSel[5] > 4'd13) |-> (slotDenied[5] && !hit[5]))
    else $error("out of range slot not refused");
  dupSlot_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
    (activationControl[4] && activationControl[5] && slotSel[4] == slotSel[5])
      |-> (slotDenied[5] && !rdReq[5]))
    else $error("second tributary on one slot");
  inactive_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    (pathTimingByteEn && !aggActivationControl) |=> (!aggOut.valid && !aggOut.driven))
    else $error("access point driven while inactive");
  aisOnes_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE17
    sfHeld_s ##0 hit[3] ##0 aggActivationControl |=> aggOut.data == 8'hff)
    else $error("all ones not inserted");
  aisBound_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE17
    aisWait_r < 18'(AIS_LIMIT_CYC))
    else $error("all ones insertion too slow");
  posSkip_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
    (hit[0] && curPhase == 2'd2 && curCol == 6'd1 && justState[0] == tmap_pkg::JUST_POS)
      |-> !rdReq[0])
    else $error("read not cancelled after positive justification");
  negExtra_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
    (hit[0] && curPhase == 2'd2 && curCol == 6'd0 && justState[0] == tmap_pkg::JUST_NEG
      && gTrib[0].fill != 4'd0) |-> rdReq[0] ##1 (gTrib[0].rdBin_r == $past(gTrib[0].rdBin_r) + 4'd1))
    else $error("extra read missing on negative justification");
endmodule

// ### tmap_trib_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// tributary sources, one free running 30 ns clock each
// ------------------------------------------------------------------
module tmap_trib_model (
  input wire logic rst_n,
  output logic [13:0] tribClk,
  output tmap_pkg::tmap_entry_t [13:0] tribIn,
  output logic [13:0] tribWrEn
);
  genvar t;
  for (t = 0; t < 14; t++) begin : g_trib
    localparam logic [3:0] TAG = 4'(t); // tributary marker in every byte
    int tick; // clock counter
    int nByte; // bytes sent so far
    // clock, phase skewed per tributary
    initial begin
      tribClk[t] = 1'b0;
      #(t * 2 + 1);
      forever #15 tribClk[t] = ~tribClk[t];
    end
    // one byte every fourth clock, a bit above the read rate so the store stays full
    initial begin
      tick = 0;
      nByte = 0;
      tribWrEn[t] = 1'b0;
      tribIn[t] = '0;
      forever begin
        @(posedge tribClk[t]);
        #1;
        tick++;
        if (rst_n && (tick % 4 == 0)) begin
          tribWrEn[t] = 1'b1;
          tribIn[t].data = {1'b0, TAG, nByte[2:0]}; // bit 7 low, never all ones
          tribIn[t].fs = (nByte % 140 == 0);
          nByte++;
        end else begin
          // released data does not keep its last value
          tribWrEn[t] = 1'b0;
          tribIn[t].data = ~tribIn[t].data;
        end
      end
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic core_clk;
  logic rst_n;
  logic [13:0] tribClk;
  tmap_pkg::tmap_entry_t [13:0] tribIn;
  logic [13:0] tribWrEn;
  logic [13:0] serverFailInput;
  logic [13:0] activationControl;
  logic [13:0][3:0] slotSel;
  logic aggActivationControl;
  logic byteEn;
  logic frameStart;
  logic mfStart;
  tmap_pkg::tmap_agg_t aggOut;
  logic [13:0] slotDenied;
  tmap_pkg::tmap_agg_t cap [0:2147]; // one captured multiframe
  int badCount;
  int nTests;
  int cycles;

  // short fail bound tightens the all ones timing check
  tmap_mapper #(.AIS_LIMIT_CYC(64)) dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tribClk(tribClk),
    .tribIn(tribIn),
    .tribWrEn(tribWrEn),
    .serverFailInput(serverFailInput),
    .activationControl(activationControl),
    .slotSel(slotSel),
    .aggActivationControl(aggActivationControl),
    .pathTimingByteEn(byteEn),
    .pathTimingFrameStart(frameStart),
    .pathTimingMultiframeStart(mfStart),
    .aggOut(aggOut),
    .slotDenied(slotDenied)
  );

  tmap_trib_model partner (
    .rst_n(rst_n),
    .tribClk(tribClk),
    .tribIn(tribIn),
    .tribWrEn(tribWrEn)
  );

  // ------------------------------------------------------------------
  // clock, hang guard, helpers
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // about 17k cycles expected, ceiling well above
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 25000) begin
      badCount++;
      results();
    end
  end

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // byte index of slot s, column c, frame f
  function int tu(input int f, input int c, input int s);
    return f * 537 + 1 + c * 14 + s;
  endfunction

  // one multiframe of byte slots, back to back, output captured a cycle later
  task automatic run_mf;
    for (int i = 0; i <= 2148; i++) begin
      @(posedge core_clk);
      #1;
      if (i > 0) begin
        cap[i - 1] = aggOut;
      end
      byteEn = (i < 2148);
      frameStart = (i < 2148) && (i % 537 == 0);
      mfStart = (i == 0);
    end
  endtask

  task step;
    @(posedge core_clk);
    #1;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_overhead;
    run_mf();
    for (int f = 0; f < 4; f++) begin
      check("status byte", cap[f * 537].data, {5'b00011, 2'(f + 1), 1'b0});
    end
    check("frame marks", {6'h0, cap[0].fs, cap[0].mfs}, 8'h03);
    check("status marks", {6'h0, cap[0].driven, cap[0].valid}, 8'h03);
    for (int s = 0; s < 14; s++) begin
      check("size bits", {6'h0, cap[1 + s].data[3:2]}, 8'h02);
      check("trib tag", {4'h0, cap[tu(0, 5, s)].data[6:3]}, 8'(13 - s));
    end
    $display("test overhead done");
  endtask

  task automatic t_denial;
    slotSel[5] = 4'd9;
    step();
    check("deny dup", {slotDenied[13:8], slotDenied[5:4]}, 8'h02);
    run_mf();
    check("slot owner", {4'h0, cap[tu(0, 5, 9)].data[6:3]}, 8'h04);
    check("free slot", {7'h0, cap[tu(0, 5, 8)].driven}, 8'h00);
    slotSel[5] = 4'he;
    step();
    check("deny range", slotDenied[7:0], 8'h20);
    slotSel[5] = 4'd8;
    step();
    check("no deny", slotDenied[7:0], 8'h00);
    $display("test denial done");
  endtask

  task automatic t_activation;
    activationControl[2] = 1'b0;
    run_mf();
    check("inactive trib", {cap[tu(0, 5, 11)].data[6:0], cap[tu(0, 5, 11)].driven}, 8'h00);
    activationControl[2] = 1'b1;
    aggActivationControl = 1'b0;
    run_mf();
    check("agg off", {6'h0, cap[0].valid, cap[tu(1, 5, 0)].driven}, 8'h00);
    aggActivationControl = 1'b1;
    $display("test activation done");
  endtask

  task automatic t_fail;
    serverFailInput[3] = 1'b1;
    run_mf();
    check("ais on", cap[tu(0, 5, 10)].data, 8'hff);
    check("ais ptr", cap[tu(0, 0, 10)].data, 8'hff);
    check("other trib", {7'h0, cap[tu(0, 5, 9)].data[7]}, 8'h00);
    serverFailInput[3] = 1'b0;
    run_mf();
    check("ais off", {4'h0, cap[tu(0, 5, 10)].data[6:3]}, 8'h03);
    $display("test fail done");
  endtask

  // ------------------------------------------------------------------
  // main sequence and verdict
  // ------------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    badCount = 0;
    nTests = 0;
    cycles = 0;
    rst_n = 1'b0;
    serverFailInput = 14'h0000;
    activationControl = 14'h3fff;
    aggActivationControl = 1'b1;
    byteEn = 1'b0;
    frameStart = 1'b0;
    mfStart = 1'b0;
    // reversed mapping, tributary t to slot 13 - t
    for (int t = 0; t < 14; t++) begin
      slotSel[t] = 4'(13 - t);
    end
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // fill the stores first
    run_mf();
    run_mf();
    t_overhead();
    t_denial();
    t_activation();
    t_fail();
    results();
  end
endmodule
